// File: mpg_pkg.sv
// Package: register offsets, reset values and carrier types of the port block
package mpg_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] MPG_PORT_A_DATA_OFF = 8'h00;
  localparam logic [7:0] MPG_PORT_B_DATA_OFF = 8'h01;
  localparam logic [7:0] MPG_PORT_C_INPUT_DATA_OFF = 8'h02;
  localparam logic [7:0] MPG_PORT_D_DATA_OFF = 8'h03;
  localparam logic [7:0] MPG_PORT_E_DATA_OFF = 8'h0c;
  localparam logic [7:0] MPG_PORT_F_OUTPUT_DATA_OFF = 8'h0d;
  localparam logic [7:0] MPG_PORT_A_DIRECTION_OFF = 8'h20;
  localparam logic [7:0] MPG_PORT_B_DIRECTION_OFF = 8'h21;
  localparam logic [7:0] MPG_PORT_D_DIRECTION_OFF = 8'h23;
  localparam logic [7:0] MPG_PORT_E_DIRECTION_OFF = 8'h2c;
  localparam logic [7:0] MPG_PORT_A_PULLUP_ENABLE_OFF = 8'h30;
  localparam logic [7:0] MPG_PORT_B_PULLUP_ENABLE_OFF = 8'h31;
  localparam logic [7:0] MPG_PORT_D_PULLUP_ENABLE_OFF = 8'h33;
  localparam logic [7:0] MPG_PORT_E_PULLUP_ENABLE_OFF = 8'h3c;
  localparam logic [7:0] MPG_ALT_SELECT_A_OFF = 8'h40;
  localparam logic [7:0] MPG_ALT_SELECT_B_OFF = 8'h41;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] MPG_DIRECTION_RST = 8'hff;
  localparam logic [7:0] MPG_DATA_RST = 8'h00;
  localparam logic [7:0] MPG_PULLUP_RST = 8'h00;
  localparam logic [7:0] MPG_ALT_RST = 8'h00;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mpg_bus_req_t;

  // Pin bundle of one bidirectional port, eight bits wide, unused bits ignored
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } mpg_pin_drive_t;

endpackage

// File: mpg_bidir_port.sv
// One bidirectional port slice: latch, direction, pull-up and alternate selector
`timescale 1ns/100ps
`default_nettype none

module mpg_bidir_port
  import mpg_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic wr_pu,
  input wire logic [7:0] wdata,
  input wire logic [WIDTH-1:0] alt_sel,
  input wire logic [WIDTH-1:0] alt_out,
  input wire logic [WIDTH-1:0] alt_oe,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] latch,
  output logic [WIDTH-1:0] dir,
  output logic [WIDTH-1:0] pu,
  output logic [WIDTH-1:0] rd_val,
  output logic [WIDTH-1:0] out_d,
  output logic [WIDTH-1:0] oe_d,
  output logic [WIDTH-1:0] pullup_d
);

  logic [WIDTH-1:0] latch_q;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] pu_q;

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= MPG_DATA_RST[WIDTH-1:0];
    end else if (wr_data) begin
      latch_q <= wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_q <= MPG_DIRECTION_RST[WIDTH-1:0];
    end else if (wr_dir) begin
      dir_q <= wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pu_q <= MPG_PULLUP_RST[WIDTH-1:0];
    end else if (wr_pu) begin
      pu_q <= wdata[WIDTH-1:0];
    end
  end

  assign latch = latch_q;
  assign dir = dir_q;
  assign pu = pu_q;

  // ************************************************************
  // Pin logic
  // ************************************************************
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      // Selector between latch and peripheral
      out_d[i] = alt_sel[i] ? alt_out[i] : latch_q[i];
      // Direction 0 drives; an alternate output also needs output mode
      oe_d[i] = !dir_q[i] && (!alt_sel[i] || alt_oe[i]);
      // Pull-up only while the pin is an input
      pullup_d[i] = dir_q[i] && pu_q[i];
      // Input mode reads the pin, output mode the latch
      rd_val[i] = dir_q[i] ? pin_in[i] : latch_q[i];
    end
  end

endmodule
`default_nettype wire

// File: mpg_top.sv
// Top of the multi-port general-purpose I/O block with its register port
// What this block does
// - Port A has four bidirectional pins, own latches, per-bit direction.
// - Port A input pins get a pull-up when their enable bit is set.
// - Reset puts every port A pin into input mode.
// - Port B has eight bidirectional pins, latches and per-bit direction.
// - Port B input pins get a pull-up per their enable bit.
// - Reset puts every port B pin into input mode.
// - Port C is four input-only pins, also analog inputs.
// - Port D: four bidirectional pins, pull-ups, input after reset, interrupt inputs.
// - Port F is one output-only pin, output right after reset.
// - Total 22 pins: 17 bidirectional, 4 input-only, 1 output-only.
// - Seventeen pull-ups, one per bidirectional pin, software controlled only.
// - A selector lets peripherals take pins instead of the latch.
// - Port A carries timer capture inputs and a timer output.
// - Direction 0 is output with buffer on, 1 input; reset all ones.
// - Data read gives pin level for inputs, latch for outputs.
// - Reset clears output latches to zero; port C read undefined.
// - Port E has one bidirectional pin with latch, direction, pull-up.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module mpg_top
  import mpg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] port_a_in,
  output logic [3:0] port_a_out,
  output logic [3:0] port_a_oe,
  output logic [3:0] port_a_pullup,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pullup,
  input wire logic [3:0] analog_inputs,
  input wire logic [3:0] port_d_in,
  output logic [3:0] port_d_out,
  output logic [3:0] port_d_oe,
  output logic [3:0] port_d_pullup,
  input wire logic port_e_in,
  output logic port_e_out,
  output logic port_e_oe,
  output logic port_e_pullup,
  output logic port_f_out,
  input wire logic timer_out,
  output logic [1:0] timer_capture_in,
  input wire logic [7:0] port_b_alt_out,
  input wire logic [7:0] port_b_alt_oe,
  output logic [7:0] port_b_alt_in,
  output logic [3:0] ext_interrupt_inputs,
  output logic ext_interrupt_e
);

  // ************************************************************
  // Register strobes
  // ************************************************************
  mpg_bus_req_t req;
  logic [7:0] alt_a_q;
  logic [7:0] alt_b_q;
  logic port_f_q;
  logic [7:0] rdata_q;

  // Bus fields travel together so one decode function serves every register
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input mpg_bus_req_t r, input logic [7:0] off);
    hit = r.wr && (r.addr == off);
  endfunction

  // ************************************************************
  // Ports A, B, D, E
  // ************************************************************
  logic [3:0] a_latch, a_dir, a_pu, a_rd, a_out_d, a_oe_d, a_pull_d;
  logic [7:0] b_latch, b_dir, b_pu, b_rd, b_out_d, b_oe_d, b_pull_d;
  logic [3:0] d_latch, d_dir, d_pu, d_rd, d_out_d, d_oe_d, d_pull_d;
  logic [0:0] e_latch, e_dir, e_pu, e_rd, e_out_d, e_oe_d, e_pull_d;

  // A, B, D and E give 17 bidirectional pins, C four inputs, F one output
  // Timer output rides on port A bit 1 when selected
  mpg_bidir_port #(.WIDTH(4)) u_port_a (
    .clk(clk),
    .rst(rst),
    .wr_data(hit(req, MPG_PORT_A_DATA_OFF)),
    .wr_dir(hit(req, MPG_PORT_A_DIRECTION_OFF)),
    .wr_pu(hit(req, MPG_PORT_A_PULLUP_ENABLE_OFF)),
    .wdata(req.wdata),
    .alt_sel(alt_a_q[3:0]),
    .alt_out({2'h0, timer_out, 1'h0}),
    .alt_oe(4'h2),
    .pin_in(port_a_in),
    .latch(a_latch),
    .dir(a_dir),
    .pu(a_pu),
    .rd_val(a_rd),
    .out_d(a_out_d),
    .oe_d(a_oe_d),
    .pullup_d(a_pull_d)
  );

  // Serial, UART and timer functions of port B come from outside peripherals
  mpg_bidir_port #(.WIDTH(8)) u_port_b (
    .clk(clk),
    .rst(rst),
    .wr_data(hit(req, MPG_PORT_B_DATA_OFF)),
    .wr_dir(hit(req, MPG_PORT_B_DIRECTION_OFF)),
    .wr_pu(hit(req, MPG_PORT_B_PULLUP_ENABLE_OFF)),
    .wdata(req.wdata),
    .alt_sel(alt_b_q),
    .alt_out(port_b_alt_out),
    .alt_oe(port_b_alt_oe),
    .pin_in(port_b_in),
    .latch(b_latch),
    .dir(b_dir),
    .pu(b_pu),
    .rd_val(b_rd),
    .out_d(b_out_d),
    .oe_d(b_oe_d),
    .pullup_d(b_pull_d)
  );

  mpg_bidir_port #(.WIDTH(4)) u_port_d (
    .clk(clk),
    .rst(rst),
    .wr_data(hit(req, MPG_PORT_D_DATA_OFF)),
    .wr_dir(hit(req, MPG_PORT_D_DIRECTION_OFF)),
    .wr_pu(hit(req, MPG_PORT_D_PULLUP_ENABLE_OFF)),
    .wdata(req.wdata),
    .alt_sel(4'h0),
    .alt_out(4'h0),
    .alt_oe(4'h0),
    .pin_in(port_d_in),
    .latch(d_latch),
    .dir(d_dir),
    .pu(d_pu),
    .rd_val(d_rd),
    .out_d(d_out_d),
    .oe_d(d_oe_d),
    .pullup_d(d_pull_d)
  );

  mpg_bidir_port #(.WIDTH(1)) u_port_e (
    .clk(clk),
    .rst(rst),
    .wr_data(hit(req, MPG_PORT_E_DATA_OFF)),
    .wr_dir(hit(req, MPG_PORT_E_DIRECTION_OFF)),
    .wr_pu(hit(req, MPG_PORT_E_PULLUP_ENABLE_OFF)),
    .wdata(req.wdata),
    .alt_sel(1'h0),
    .alt_out(1'h0),
    .alt_oe(1'h0),
    .pin_in(port_e_in),
    .latch(e_latch),
    .dir(e_dir),
    .pu(e_pu),
    .rd_val(e_rd),
    .out_d(e_out_d),
    .oe_d(e_oe_d),
    .pullup_d(e_pull_d)
  );

  // ************************************************************
  // Alternate select and output-only port
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      alt_a_q <= MPG_ALT_RST;
    end else if (hit(req, MPG_ALT_SELECT_A_OFF)) begin
      alt_a_q <= {4'h0, req.wdata[3:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alt_b_q <= MPG_ALT_RST;
    end else if (hit(req, MPG_ALT_SELECT_B_OFF)) begin
      alt_b_q <= req.wdata;
    end
  end

  // Port F has no direction bit, so a defined low in reset is all it needs
  // Driven low in reset, always an output
  always_ff @(posedge clk) begin
    if (rst) begin
      port_f_q <= MPG_DATA_RST[0];
    end else if (hit(req, MPG_PORT_F_OUTPUT_DATA_OFF)) begin
      port_f_q <= req.wdata[0];
    end
  end

  // ************************************************************
  // Pin registers
  // ************************************************************
  // Pins are registered so every output leaves a flip-flop; one cycle of lag
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_oe <= 4'h0;
      port_b_oe <= 8'h00;
      port_d_oe <= 4'h0;
      port_e_oe <= 1'h0;
    end else begin
      port_a_oe <= a_oe_d;
      port_b_oe <= b_oe_d;
      port_d_oe <= d_oe_d;
      port_e_oe <= e_oe_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_out <= 4'h0;
      port_b_out <= 8'h00;
      port_d_out <= 4'h0;
      port_e_out <= 1'h0;
      port_f_out <= 1'h0;
    end else begin
      port_a_out <= a_out_d;
      port_b_out <= b_out_d;
      port_d_out <= d_out_d;
      port_e_out <= e_out_d;
      port_f_out <= port_f_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_pullup <= 4'h0;
      port_b_pullup <= 8'h00;
      port_d_pullup <= 4'h0;
      port_e_pullup <= 1'h0;
    end else begin
      port_a_pullup <= a_pull_d;
      port_b_pullup <= b_pull_d;
      port_d_pullup <= d_pull_d;
      port_e_pullup <= e_pull_d;
    end
  end

  // Peripheral-facing inputs; pins pass through regardless of mode
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_capture_in <= 2'h0;
      port_b_alt_in <= 8'h00;
      ext_interrupt_inputs <= 4'h0;
      ext_interrupt_e <= 1'h0;
    end else begin
      timer_capture_in <= port_a_in[1:0];
      port_b_alt_in <= port_b_in;
      ext_interrupt_inputs <= port_d_in;
      ext_interrupt_e <= port_e_in;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Port C has no latch, so its read shows the live pins even after reset
  // Unused high direction bits read as one, other unused bits as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        MPG_PORT_A_DATA_OFF: rdata_q <= {4'h0, a_rd};
        MPG_PORT_B_DATA_OFF: rdata_q <= b_rd;
        MPG_PORT_C_INPUT_DATA_OFF: rdata_q <= {4'h0, analog_inputs};
        MPG_PORT_D_DATA_OFF: rdata_q <= {4'h0, d_rd};
        MPG_PORT_E_DATA_OFF: rdata_q <= {7'h00, e_rd};
        MPG_PORT_F_OUTPUT_DATA_OFF: rdata_q <= {7'h00, port_f_q};
        MPG_PORT_A_DIRECTION_OFF: rdata_q <= {4'hf, a_dir};
        MPG_PORT_B_DIRECTION_OFF: rdata_q <= b_dir;
        MPG_PORT_D_DIRECTION_OFF: rdata_q <= {4'hf, d_dir};
        MPG_PORT_E_DIRECTION_OFF: rdata_q <= {7'h7f, e_dir};
        MPG_PORT_A_PULLUP_ENABLE_OFF: rdata_q <= {4'h0, a_pu};
        MPG_PORT_B_PULLUP_ENABLE_OFF: rdata_q <= b_pu;
        MPG_PORT_D_PULLUP_ENABLE_OFF: rdata_q <= {4'h0, d_pu};
        MPG_PORT_E_PULLUP_ENABLE_OFF: rdata_q <= {7'h00, e_pu};
        MPG_ALT_SELECT_A_OFF: rdata_q <= alt_a_q;
        MPG_ALT_SELECT_B_OFF: rdata_q <= alt_b_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // Latch outputs of the slices are unread; alternate selects feed the pin logic
  logic unused_ok;
  assign unused_ok = ^{a_latch, b_latch, d_latch, e_latch};

endmodule
`default_nettype wire

// File: mpg_top_monitor.sv
// Checker of the port block's register port and pin outputs
`timescale 1ns/100ps
`default_nettype none
module mpg_top_monitor
  import mpg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] port_a_oe,
  input wire logic [3:0] port_a_pullup,
  input wire logic [7:0] port_b_oe,
  input wire logic [7:0] port_b_pullup,
  input wire logic [3:0] port_d_oe,
  input wire logic [3:0] port_d_pullup,
  input wire logic port_e_oe,
  input wire logic port_e_pullup,
  input wire logic port_f_out
);
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_state: assert property (
    $fell(rst) |-> !port_a_oe && !port_b_oe && !port_d_oe && !port_e_oe && !port_f_out)
    else $error("pins not released by reset");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
  a_pull_only_in: assert property (
    !(port_a_oe & port_a_pullup) && !(port_b_oe & port_b_pullup)
    && !(port_d_oe & port_d_pullup) && !(port_e_oe & port_e_pullup))
    else $error("pull-up on a driven pin");
  a_dir_to_oe: assert property (
    $past(reg_wr, 2) && $past(reg_addr, 2) == MPG_PORT_A_DIRECTION_OFF && !$past(rst)
    |-> port_a_oe == ~$past(reg_wdata[3:0], 2)) else $error("direction not applied");
  a_pull_b_set: assert property (
    $past(reg_wr, 2) && $past(reg_addr, 2) == MPG_PORT_B_PULLUP_ENABLE_OFF && !$past(rst)
    && port_b_oe == 8'h00 |-> port_b_pullup == $past(reg_wdata, 2))
    else $error("pull-up enable not applied");
  a_port_f_drive: assert property (
    $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h0d && !$past(rst)
    |-> port_f_out == $past(reg_wdata[0], 2)) else $error("output-only pin not driven");
  a_rd_narrow: assert property (
    $past(reg_rd) && ($past(reg_addr) == 8'h00 || $past(reg_addr) == 8'h03)
    |-> reg_rdata[7:4] == 4'h0) else $error("unused data bits not zero");
  a_rd_dir_pad: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h2c |-> reg_rdata[7:1] == 7'h7f)
    else $error("unused direction bits not one");
  a_unmapped_rd: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h10 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind mpg_top mpg_top_monitor u_mon (.*);
`default_nettype wire

// File: mpg_pin_model.sv
// External circuitry on one port: drives, pulls up or leaves pins floating
`timescale 1ns/100ps
`default_nettype none
module mpg_pin_model #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pu_en,
  input wire logic [W-1:0] ext,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin
);
  logic [W-1:0] flt = '0;
  // A floating pin wanders every cycle, so a stale level cannot pass for a real one
  always @(posedge clk) begin
    flt <= ~flt;
  end
  assign pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu_en | flt));
endmodule
`default_nettype wire

// File: test_multi_port_gpio_block.sv
// Self-checking bench of the port block: register tasks and pin checks
`timescale 1ns/100ps
`default_nettype none
module test_multi_port_gpio_block;
  import mpg_pkg::*;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] port_a_in, port_a_out, port_a_oe, port_a_pullup, a_ext = 4'h0, a_en = 4'h0;
  logic [7:0] port_b_in, port_b_out, port_b_oe, port_b_pullup, b_ext = 8'h00, b_en = 8'h00;
  logic [7:0] port_b_alt_out = 8'h00, port_b_alt_oe = 8'h00, port_b_alt_in;
  logic [3:0] port_d_in, port_d_out, port_d_oe, port_d_pullup, d_ext = 4'h0, d_en = 4'h0;
  logic [3:0] analog_inputs = 4'h0, ext_interrupt_inputs;
  logic port_e_in, port_e_out, port_e_oe, port_e_pullup, e_ext = 1'b0, e_en = 1'b0;
  logic port_f_out, timer_out = 1'b0, ext_interrupt_e;
  logic [1:0] timer_capture_in;
  int fails = 0, n_tests = 0;
  mpg_top DUT (.*);
  mpg_pin_model #(.W(4)) u_a (.clk(clk), .out(port_a_out), .oe(port_a_oe),
    .pu_en(port_a_pullup), .ext(a_ext), .ext_en(a_en), .pin(port_a_in));
  mpg_pin_model #(.W(8)) u_b (.clk(clk), .out(port_b_out), .oe(port_b_oe),
    .pu_en(port_b_pullup), .ext(b_ext), .ext_en(b_en), .pin(port_b_in));
  mpg_pin_model #(.W(4)) u_d (.clk(clk), .out(port_d_out), .oe(port_d_oe),
    .pu_en(port_d_pullup), .ext(d_ext), .ext_en(d_en), .pin(port_d_in));
  mpg_pin_model #(.W(1)) u_e (.clk(clk), .out(port_e_out), .oe(port_e_oe),
    .pu_en(port_e_pullup), .ext(e_ext), .ext_en(e_en), .pin(port_e_in));
  initial begin
    forever #4 clk = ~clk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  // Pins follow a register two edges after its strobe
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic chk_reset;
    rd(8'h20, 8'hff);
    rd(8'h21, 8'hff);
    rd(8'h23, 8'hff);
    rd(8'h2c, 8'hff);
    rd(8'h31, 8'h00);
    chk("port_b_oe", 8'h00, port_b_oe);
    chk("port_f_out", 8'h00, {7'h0, port_f_out});
  endtask
  task automatic test_done;
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_reset;
    chk("bidir_pins", 8'h11, 8'($bits(port_a_oe) + $bits(port_b_oe) + $bits(port_d_oe) + 1));
    chk("all_pins", 8'h16, 8'($bits(port_a_oe) + $bits(port_b_oe) + $bits(port_d_oe) + 1
      + $bits(analog_inputs) + $bits(port_f_out)));
    a_ext <= 4'ha;
    a_en <= 4'hf;
    b_ext <= 8'h5c;
    b_en <= 8'hff;
    d_ext <= 4'h3;
    d_en <= 4'hf;
    e_ext <= 1'b1;
    e_en <= 1'b1;
    analog_inputs <= 4'h9;
    settle;
    rd(8'h00, 8'h0a);
    rd(8'h01, 8'h5c);
    rd(8'h02, 8'h09);
    rd(8'h03, 8'h03);
    rd(8'h0c, 8'h01);
    chk("ext_interrupt_inputs", 8'h03, {4'h0, ext_interrupt_inputs});
    chk("ext_interrupt_e", 8'h01, {7'h0, ext_interrupt_e});
    // Writes to the input-only port and to a hole are ignored
    wr(8'h02, 8'h00);
    wr(8'h10, 8'h55);
    rd(8'h02, 8'h09);
    rd(8'h10, 8'h00);
    wr(8'h30, 8'h0f);
    wr(8'h31, 8'hff);
    wr(8'h33, 8'hff);
    wr(8'h3c, 8'h01);
    a_en <= 4'h0;
    settle;
    chk("port_b_pullup", 8'hff, port_b_pullup);
    chk("port_d_pullup", 8'h0f, {4'h0, port_d_pullup});
    chk("port_e_pullup", 8'h01, {7'h0, port_e_pullup});
    rd(8'h00, 8'h0f);
    wr(8'h00, 8'h05);
    wr(8'h20, 8'h0c);
    settle;
    chk("port_a_oe", 8'h03, {4'h0, port_a_oe});
    chk("port_a_pullup", 8'h0c, {4'h0, port_a_pullup});
    chk("timer_capture_in", 8'h01, {6'h0, timer_capture_in});
    rd(8'h00, 8'h0d);
    wr(8'h01, 8'ha5);
    wr(8'h21, 8'h0f);
    wr(8'h03, 8'h06);
    wr(8'h23, 8'h00);
    wr(8'h0c, 8'h01);
    wr(8'h2c, 8'hfe);
    wr(8'h0d, 8'h01);
    settle;
    chk("port_b_oe", 8'hf0, port_b_oe);
    chk("port_b_out", 8'ha0, port_b_out & 8'hf0);
    chk("port_d_out", 8'h06, {4'h0, port_d_out});
    chk("port_e_oe", 8'h01, {7'h0, port_e_oe});
    chk("port_e_out", 8'h01, {7'h0, port_e_out});
    chk("port_d_oe", 8'h0f, {4'h0, port_d_oe});
    chk("port_f_out", 8'h01, {7'h0, port_f_out});
    rd(8'h01, 8'hac);
    rd(8'h03, 8'h06);
    rd(8'h0c, 8'h01);
    rd(8'h0d, 8'h01);
    // Peripherals take pins through the selector
    wr(8'h40, 8'h02);
    timer_out <= 1'b1;
    settle;
    chk("port_a_out", 8'h02, {4'h0, port_a_out} & 8'h02);
    port_b_alt_out <= 8'h3c;
    port_b_alt_oe <= 8'hff;
    wr(8'h21, 8'h00);
    wr(8'h41, 8'hff);
    settle;
    chk("port_b_out", 8'h3c, port_b_out);
    chk("port_b_alt_in", 8'h3c, port_b_alt_in);
    // Second reset in mid-run; directions and latches must be back at reset values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_reset;
    wr(8'h20, 8'h00);
    settle;
    chk("port_a_out", 8'h00, {4'h0, port_a_out});
    rd(8'h00, 8'h00);
    test_done;
  end
endmodule
`default_nettype wire
